// ==== design/low_power_mode_controller.sv ====
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "lpmc_defs.svh"

module low_power_mode_controller (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic wb_err_o,
  input wire logic core_deep_sleep_request_i,
  input wire logic [5:0] wake_pin_i,
  input wire logic rtc_wake_event_i,
  input wire logic main_regulator_ready_i,
  input wire logic regulator_voltage_ready_i,
  output logic low_power_regulator_select_o,
  output logic [1:0] deep_sleep_core_voltage_select_o,
  output logic backup_write_enable_o,
  output logic [5:0] wake_pin_pulldown_o,
  output logic io_hold_hiz_o,
  output logic periph_clock_gate_o,
  output logic [1:0] flash_power_ctrl_o,
  output logic deep_sleep_active_o,
  output logic deep_sleep1_active_o,
  output logic standby_active_o,
  output logic standby_wake_reset_o
);

  // ----------------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------------
  logic [31:0] mode_ctrl_r;
  logic [31:0] cs_en_r;
  logic [31:0] flash_ctrl_r;
  logic stby_flag_r;
  logic wake_flag_r;
  logic main_rdy_r;
  logic vsel_rdy_r;
  logic [5:0] wake_pin_d_r;
  logic [5:0] wake_en_d_r;
  lpmc_pkg::pwr_state_t state_r;
  lpmc_pkg::pwr_state_t state_nxt;

  // ----------------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------------
  wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  wire hit_mode = (wb_adr_i == `OFS_MODE_CTRL);
  wire hit_cs = (wb_adr_i == `OFS_CTRL_STAT);
  wire hit_flash = (wb_adr_i == `OFS_FLASH_CTRL);
  wire hit_any = hit_mode | hit_cs | hit_flash;
  // Half-word or word only on flash control.
  wire flash_sel_ok = (wb_sel_i == 4'h3) | (wb_sel_i == 4'hC) |
                      (wb_sel_i == 4'hF);
  wire bad_access = bus_req & (~hit_any | (hit_flash & ~flash_sel_ok));
  // A refused access must leave every register untouched.
  wire wr_ok = bus_req & wb_we_i & hit_any & ~bad_access;
  wire [31:0] byte_mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
                           {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  wire [31:0] wr_data = wb_dat_i & byte_mask;
  wire wr_mode = wr_ok & hit_mode;
  wire wr_cs = wr_ok & hit_cs;
  wire wr_flash = wr_ok & hit_flash;

  // Write-one-to-clear strobes; the bits never store.
  wire stby_clr = wr_mode & wr_data[`BIT_STBY_CLR];
  wire wake_clr = wr_mode & wr_data[`BIT_WAKE_CLR];

  wire [31:0] mode_ctrl_nxt = (mode_ctrl_r & ~(byte_mask & `MASK_MODE_CTRL))
                            | (wr_data & `MASK_MODE_CTRL);
  wire [31:0] cs_en_nxt = (cs_en_r & ~(byte_mask & `MASK_CTRL_STAT))
                        | (wr_data & `MASK_CTRL_STAT);
  wire [31:0] flash_nxt = (flash_ctrl_r & ~(byte_mask & `MASK_FLASH_CTRL))
                        | (wr_data & `MASK_FLASH_CTRL);

  // ----------------------------------------------------------------------
  // Wake detection
  // ----------------------------------------------------------------------
  wire [5:0] wake_en = {cs_en_r[`BIT_WAKE5_EN], 1'b0, cs_en_r[11:8]};
  // Rising edge, or a pin already high when its enable turns on.
  wire [5:0] pin_rise = wake_pin_i & ~wake_pin_d_r & wake_en;
  wire [5:0] en_rise = wake_pin_i & wake_en & ~wake_en_d_r;
  wire pin_wake = |(pin_rise | en_rise);
  // RTC events wake from every deep state; GPIO only through wake pins.
  wire wake_evt = pin_wake | rtc_wake_event_i;

  wire [31:0] cs_read = {15'h0000, main_rdy_r, 1'b0, vsel_rdy_r,
                         cs_en_r[13:8], 6'h00, stby_flag_r, wake_flag_r};
  wire [31:0] rd_mux = hit_mode ? mode_ctrl_r :
                       hit_cs ? cs_read :
                       hit_flash ? flash_ctrl_r : 32'h0000_0000;

  // ----------------------------------------------------------------------
  // Power state sequencer
  // ----------------------------------------------------------------------
  wire [1:0] lp_sel = mode_ctrl_r[`BIT_LPSEL_HI:`BIT_LPSEL_LO];

  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      lpmc_pkg::ST_RUN: begin
        if (core_deep_sleep_request_i) begin
          unique case (lpmc_pkg::lp_sel_t'(lp_sel))
            lpmc_pkg::LP_DEEP_SLEEP: state_nxt = lpmc_pkg::ST_DEEP_SLEEP;
            lpmc_pkg::LP_DEEP_SLEEP1: state_nxt = lpmc_pkg::ST_DEEP_SLEEP1;
            lpmc_pkg::LP_STANDBY: state_nxt = lpmc_pkg::ST_STANDBY;
            default: state_nxt = lpmc_pkg::ST_RUN;
          endcase
        end
      end
      lpmc_pkg::ST_DEEP_SLEEP, lpmc_pkg::ST_DEEP_SLEEP1: begin
        if (wake_evt) begin
          state_nxt = lpmc_pkg::ST_RUN;
        end
      end
      lpmc_pkg::ST_STANDBY: begin
        if (wake_evt) begin
          state_nxt = lpmc_pkg::ST_WAKE;
        end
      end
      lpmc_pkg::ST_WAKE: state_nxt = lpmc_pkg::ST_RUN;
    endcase
  end

  // Leaving standby resets mode control only.
  wire stby_wake = (state_r == lpmc_pkg::ST_STANDBY) & wake_evt;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= lpmc_pkg::ST_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || stby_wake) begin
      mode_ctrl_r <= `RST_MODE_CTRL;
    end else if (wr_mode) begin
      mode_ctrl_r <= mode_ctrl_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cs_en_r <= `RST_CTRL_STAT;
    end else if (wr_cs) begin
      cs_en_r <= cs_en_nxt;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_ctrl_r <= `RST_FLASH_CTRL;
    end else if (wr_flash) begin
      flash_ctrl_r <= flash_nxt;
    end
  end

  // ----------------------------------------------------------------------
  // Event flags
  // ----------------------------------------------------------------------
  // Sticky flags: a setting event wins over a clear in the same cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stby_flag_r <= 1'b0;
    end else if (state_r == lpmc_pkg::ST_STANDBY) begin
      stby_flag_r <= 1'b1;
    end else if (stby_clr) begin
      stby_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_flag_r <= 1'b0;
    end else if (wake_evt) begin
      wake_flag_r <= 1'b1;
    end else if (wake_clr) begin
      wake_flag_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Status mirrors and edge history
  // ----------------------------------------------------------------------
  // Regulator readiness reaches software one cycle after the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      main_rdy_r <= 1'b0;
    end else begin
      main_rdy_r <= main_regulator_ready_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vsel_rdy_r <= 1'b0;
    end else begin
      vsel_rdy_r <= regulator_voltage_ready_i;
    end
  end

  // History resets low, the idle level of a pulled-down pin, so no edge.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_pin_d_r <= 6'h00;
    end else begin
      wake_pin_d_r <= wake_pin_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_en_d_r <= 6'h00;
    end else begin
      wake_en_d_r <= wake_en;
    end
  end

  // ----------------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------------
  // Each answer is a one-cycle pulse; read data is zero outside it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req & ~bad_access;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_err_o <= 1'b0;
    end else begin
      wb_err_o <= bad_access;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_dat_o <= (bus_req & ~wb_we_i & ~bad_access) ? rd_mux : 32'h0000_0000;
    end
  end

  // ----------------------------------------------------------------------
  // Power outputs
  // ----------------------------------------------------------------------
  // State outputs follow the next state, so they line up with state_r.
  wire in_ds = (state_nxt == lpmc_pkg::ST_DEEP_SLEEP);
  wire in_ds1 = (state_nxt == lpmc_pkg::ST_DEEP_SLEEP1);
  wire in_sb = (state_nxt == lpmc_pkg::ST_STANDBY);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_power_regulator_select_o <= 1'b0;
    end else begin
      low_power_regulator_select_o <= mode_ctrl_r[`BIT_LP_REG_EN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deep_sleep_core_voltage_select_o <= 2'h1;
    end else begin
      deep_sleep_core_voltage_select_o <=
        mode_ctrl_r[`BIT_DS_VSEL_HI:`BIT_DS_VSEL_LO];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      backup_write_enable_o <= 1'b0;
    end else begin
      backup_write_enable_o <= mode_ctrl_r[`BIT_BKP_WEN];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wake_pin_pulldown_o <= 6'h00;
    end else begin
      wake_pin_pulldown_o <= wake_en;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      io_hold_hiz_o <= 1'b0;
    end else begin
      io_hold_hiz_o <= in_sb;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periph_clock_gate_o <= 1'b0;
    end else begin
      periph_clock_gate_o <= in_ds | in_ds1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_power_ctrl_o <= 2'h0;
    end else begin
      flash_power_ctrl_o <=
        flash_ctrl_r[`BIT_FLASH_DS_OFF:`BIT_FLASH_RUN_OFF];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deep_sleep_active_o <= 1'b0;
    end else begin
      deep_sleep_active_o <= in_ds;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      deep_sleep1_active_o <= 1'b0;
    end else begin
      deep_sleep1_active_o <= in_ds1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      standby_active_o <= 1'b0;
    end else begin
      standby_active_o <= in_sb;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      standby_wake_reset_o <= 1'b0;
    end else begin
      standby_wake_reset_o <= stby_wake;
    end
  end

endmodule : low_power_mode_controller
`default_nettype wire

// ==== design/lpmc_defs.svh ====
`ifndef LPMC_DEFS_SVH
`define LPMC_DEFS_SVH

// Register word offsets (byte addresses).
`define OFS_MODE_CTRL 8'h00
`define OFS_CTRL_STAT 8'h04
`define OFS_FLASH_CTRL 8'h08
`define OFS_SEQ_CTRL 8'h0C

// Reset values.
`define RST_MODE_CTRL 32'h0002_9000
`define RST_CTRL_STAT 32'h0000_0000
`define RST_FLASH_CTRL 32'h0000_0000

// Field positions in power_mode_control.
`define BIT_LP_REG_EN 18
`define BIT_DS_VSEL_HI 13
`define BIT_DS_VSEL_LO 12
`define BIT_BKP_WEN 8
`define BIT_STBY_CLR 3
`define BIT_WAKE_CLR 2
`define BIT_LPSEL_HI 1
`define BIT_LPSEL_LO 0

// Field positions in power_control_status.
`define BIT_MAIN_RDY 16
`define BIT_VSEL_RDY 14
`define BIT_WAKE5_EN 13
`define BIT_STBY_FLAG 1
`define BIT_WAKE_FLAG 0

// Field positions in flash_power_control.
`define BIT_FLASH_DS_OFF 5
`define BIT_FLASH_RUN_OFF 4

// Writable masks.
`define MASK_MODE_CTRL 32'h0004_3103
`define MASK_CTRL_STAT 32'h0000_2F00
`define MASK_FLASH_CTRL 32'h0000_0030

// Regulator settle time in ns and derived cycle count at 10 MHz.
`define CLK_PERIOD_NS 100
`define REG_SETTLE_NS 2000
`define REG_SETTLE_CYC ((`REG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// ==== design/lpmc_pkg.sv ====
`default_nettype none
package lpmc_pkg;

  typedef enum logic [1:0] {
    LP_DEEP_SLEEP,
    LP_DEEP_SLEEP1,
    LP_RESERVED,
    LP_STANDBY
  } lp_sel_t;

  typedef enum logic [2:0] {
    ST_RUN,
    ST_DEEP_SLEEP,
    ST_DEEP_SLEEP1,
    ST_STANDBY,
    ST_WAKE
  } pwr_state_t;

endpackage : lpmc_pkg
`default_nettype wire

// ==== tb/core_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module core_model (
  input wire logic clk_i,
  input wire logic sleep_i,
  output logic core_deep_sleep_request_o
);
  // The bench asks for sleep only from run, with the regulator enable clear.
  always_ff @(posedge clk_i) begin
    core_deep_sleep_request_o <= sleep_i;
  end
endmodule : core_model
`default_nettype wire

// ==== tb/lpmc_properties.sv ====
`timescale 1ns/1ps
`default_nettype none
module lpmc_checker (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic io_hold_hiz_o,
  input wire logic periph_clock_gate_o,
  input wire logic deep_sleep_active_o,
  input wire logic deep_sleep1_active_o,
  input wire logic standby_active_o,
  input wire logic standby_wake_reset_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire logic take = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire logic rd = wb_ack_o && !wb_we_i;
  property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack too long");
  property p_answer; take |=> (wb_ack_o ^ wb_err_o); endproperty
  a_answer: assert property (p_answer) else $error("no answer");
  property p_unmapped; take && wb_adr_i == 8'h0C |=> wb_err_o; endproperty
  a_unmapped: assert property (p_unmapped) else $error("no err");
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0000_0000; endproperty
  a_dat_idle: assert property (p_dat_idle) else $error("data not zero");
  property p_rd_ctrl;
    rd && wb_adr_i == 8'h00 |-> (wb_dat_o & 32'hFFF9_4EFC) == 32'h0;
  endproperty
  a_rd_ctrl: assert property (p_rd_ctrl) else $error("ctrl bits");
  property p_rd_stat;
    rd && wb_adr_i == 8'h04 |-> (wb_dat_o & 32'hFFFE_90FC) == 32'h0;
  endproperty
  a_rd_stat: assert property (p_rd_stat) else $error("status bits");
  property p_hiz; io_hold_hiz_o == standby_active_o; endproperty
  a_hiz: assert property (p_hiz) else $error("pins not floated");
  property p_gate;
    periph_clock_gate_o == (deep_sleep_active_o || deep_sleep1_active_o);
  endproperty
  a_gate: assert property (p_gate) else $error("clock gate");
  property p_one_state;
    $onehot0({deep_sleep_active_o, deep_sleep1_active_o, standby_active_o});
  endproperty
  a_one_state: assert property (p_one_state) else $error("states");
  property p_wake_rst;
    standby_wake_reset_o |->
      ($past(standby_active_o) || $past(standby_active_o, 2))
      ##1 !standby_wake_reset_o;
  endproperty
  a_wake_rst: assert property (p_wake_rst) else $error("wake reset");
  c_err: cover property (take && wb_adr_i == 8'h0C);
  c_stby: cover property (standby_active_o);
  c_ds1: cover property (deep_sleep1_active_o);
endmodule : lpmc_checker
bind low_power_mode_controller lpmc_checker u_lpmc_checker (.clk_i, .rst_i,
  .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_dat_o, .wb_ack_o, .wb_err_o,
  .io_hold_hiz_o, .periph_clock_gate_o, .deep_sleep_active_o,
  .deep_sleep1_active_o, .standby_active_o, .standby_wake_reset_o);
`default_nettype wire

// ==== tb/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, sleep = 0, rtc = 0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0000_0000, q, rdat;
  logic [5:0] pin = 6'h00, pd;
  logic ack, err, req, lpr, bkp, hiz, gate, ds, ds1, sb, swr;
  logic nrdy = 0, vrdy = 0;
  logic [1:0] vs, fp;
  int n_errors = 0, total_checks = 0;
  core_model u_core_model (.clk_i(clk_i), .sleep_i(sleep),
    .core_deep_sleep_request_o(req));
  low_power_mode_controller u_low_power_mode_controller (.clk_i(clk_i),
    .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .wb_err_o(err), .core_deep_sleep_request_i(req),
    .wake_pin_i(pin), .rtc_wake_event_i(rtc), .main_regulator_ready_i(nrdy),
    .regulator_voltage_ready_i(vrdy), .low_power_regulator_select_o(lpr),
    .deep_sleep_core_voltage_select_o(vs), .backup_write_enable_o(bkp),
    .wake_pin_pulldown_o(pd), .io_hold_hiz_o(hiz), .periph_clock_gate_o(gate),
    .flash_power_ctrl_o(fp), .deep_sleep_active_o(ds),
    .deep_sleep1_active_o(ds1), .standby_active_o(sb),
    .standby_wake_reset_o(swr));
  initial forever #50 clk_i = ~clk_i;
  // --------------------------------------------------------------------
  // Bus and compare tasks.
  // --------------------------------------------------------------------
  task end_of_test;
    if (n_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s, output logic e);
    int n;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= s;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (!(ack || err) && n < 20);
    if (!(ack || err)) begin
      n_errors++;
      end_of_test;
    end
    q = rdat;
    e = err;
    cyc <= 0; stb <= 0;
  endtask : bus
  task rd(input logic [7:0] a, input logic [31:0] exp);
    logic e;
    bus(0, a, 32'h0000_0000, 4'hF, e);
    chk(q, exp);
  endtask : rd
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic e;
    bus(1, a, d, 4'hF, e);
  endtask : wr
  // --------------------------------------------------------------------
  // Scenarios.
  // --------------------------------------------------------------------
  task t_regs;
    logic e;
    rd(8'h00, 32'h0002_9000);
    rd(8'h04, 32'h0000_0000);
    nrdy <= 1;
    vrdy <= 1;
    rd(8'h04, 32'h0001_4000);
    bus(0, 8'h0C, 32'h0000_0000, 4'hF, e);
    chk({31'h0, e}, 32'h0000_0001);
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 32'h0006_B103);
    chk({28'h0, lpr, vs, bkp}, 32'h0000_000F);
    bus(1, 8'h08, 32'h0000_FFFF, 4'h3, e);
    rd(8'h08, 32'h0000_0030);
    bus(1, 8'h08, 32'h0000_0000, 4'h1, e);
    chk({29'h0, e, fp}, 32'h0000_0007);
  endtask : t_regs
  task t_sleep(input logic [1:0] m);
    wr(8'h00, 32'h0000_1000 | {30'h0, m});
    wr(8'h04, 32'h0000_0100);
    sleep <= 1;
    repeat (4) @(posedge clk_i);
    chk({27'h0, gate, hiz, ds, ds1, sb},
        {27'h0, m != 3, m == 3, m == 0, m == 1, m == 3});
    sleep <= 0;
    repeat (2) @(posedge clk_i);
    pin[0] <= 1;
    repeat (2) @(posedge clk_i);
    chk({31'h0, swr}, {31'h0, m == 3});
    repeat (2) @(posedge clk_i);
    chk({28'h0, gate, ds, ds1, sb}, 32'h0);
    rd(8'h00, m == 3 ? 32'h0002_9000 : 32'h0002_9000 | {30'h0, m});
    rd(8'h04, m == 3 ? 32'h0001_4103 : 32'h0001_4101);
    wr(8'h00, 32'h0000_100C);
    pin[0] <= 0;
    rd(8'h04, 32'h0001_4100);
  endtask : t_sleep
  task t_early;
    pin[1] <= 1;
    wr(8'h04, 32'h0000_0300);
    rd(8'h04, 32'h0001_4301);
    chk({26'h0, pd}, 32'h0000_0003);
    rtc <= 1;
    wr(8'h00, 32'h0000_1004);
    rtc <= 0;
    rd(8'h04, 32'h0001_4301);
    wr(8'h00, 32'h0000_1004);
    rd(8'h04, 32'h0001_4300);
    rtc <= 1;
    @(posedge clk_i);
    rtc <= 0;
    rd(8'h04, 32'h0001_4301);
  endtask : t_early
  task t_reserved;
    wr(8'h00, 32'h0000_1002);
    sleep <= 1;
    repeat (4) @(posedge clk_i);
    chk({27'h0, gate, hiz, ds, ds1, sb}, 32'h0);
    sleep <= 0;
    repeat (2) @(posedge clk_i);
  endtask : t_reserved
  initial begin
    repeat (2) @(posedge clk_i);
    rst_i <= 0;
    t_regs;
    for (int m = 0; m < 4; m++) if (m != 2) t_sleep(m[1:0]);
    t_reserved;
    t_early;
    end_of_test;
  end
endmodule : tb
`default_nettype wire
